// ===== rtl/imo_pkg.sv
// How it works
// - Rate scale factor per build variant: 160, 40 or 10 codes per deg/s.
// - Rate high word is two's complement, zero rotation reads as zero.
// - Rate high word full scale is +20000 / -20000 for every variant.
// - Each rate axis has a low word extending resolution below the high word.
// - Rate 32-bit value full scale is 4e200000 / b1e00000 hex.
// - Rate x low word at byte 0x04, high word at 0x06, read only.
// - Rate y low word at byte 0x08, high word at 0x0a, read only.
// - Rate z low word at byte 0x0c, high word at 0x0e, read only.
// - Accel high word code is 1.25 mg, +-40 g reads +-32000.
// - Accel 32-bit value full scale is 7d000000 / 83000000 hex.
// - Accel high words at 0x12, 0x16, 0x1a, low words two below.
// - Each rate axis is exactly two words forming one 32-bit value.
package imo_pkg;

    // Serial frame
    localparam logic [3:0]  FRAME_LAST_BIT = 4'hf;
    localparam int          CMD_WRITE_BIT  = 15;

    // Register byte addresses (even byte of each word)
    localparam logic [6:0]  ADDR_RATE_X_LO  = 7'h04;
    localparam logic [6:0]  ADDR_RATE_X_HI  = 7'h06;
    localparam logic [6:0]  ADDR_RATE_Y_LO  = 7'h08;
    localparam logic [6:0]  ADDR_RATE_Y_HI  = 7'h0a;
    localparam logic [6:0]  ADDR_RATE_Z_LO  = 7'h0c;
    localparam logic [6:0]  ADDR_RATE_Z_HI  = 7'h0e;
    localparam logic [6:0]  ADDR_ACCEL_X_LO = 7'h10;
    localparam logic [6:0]  ADDR_ACCEL_X_HI = 7'h12;
    localparam logic [6:0]  ADDR_ACCEL_Y_LO = 7'h14;
    localparam logic [6:0]  ADDR_ACCEL_Y_HI = 7'h16;
    localparam logic [6:0]  ADDR_ACCEL_Z_LO = 7'h18;
    localparam logic [6:0]  ADDR_ACCEL_Z_HI = 7'h1a;

    // Reply for unmapped addresses and after a write frame
    localparam logic [15:0] UNMAPPED_WORD = 16'h0000;
    localparam logic [15:0] WORD_RESET    = 16'h0000;

    // Rate scale factors, codes per deg/s
    localparam int RATE_SCALE_125    = 160;
    localparam int RATE_SCALE_500    = 40;
    localparam int RATE_SCALE_2000   = 10;
    localparam int RATE_SCALE_FINEST = RATE_SCALE_125;

    // Full-scale 32-bit codes
    localparam logic [31:0] RATE_FS_POS  = 32'h4e200000;
    localparam logic [31:0] RATE_FS_NEG  = 32'hb1e00000;
    localparam logic [31:0] ACCEL_FS_POS = 32'h7d000000;
    localparam logic [31:0] ACCEL_FS_NEG = 32'h83000000;

    typedef enum logic [1:0] {VAR_125, VAR_500, VAR_2000} imo_variant_t;

    // One axis as seen by the host: high word over low word
    typedef struct packed {
        logic [15:0] hi;
        logic [15:0] lo;
    } imo_axis_t;

    typedef struct packed {
        imo_axis_t [2:0] rate;
        imo_axis_t [2:0] accel;
    } imo_bank_t;

    // Raw sample: rate in 1/(160*2^16) deg/s, accel in 1.25/2^16 mg
    typedef struct packed {
        logic [2:0][31:0] rate;
        logic [2:0][31:0] accel;
    } imo_raw_t;

    function automatic int imo_scale_factor(imo_variant_t v);
        case (v)
            VAR_500:  return RATE_SCALE_500;
            VAR_2000: return RATE_SCALE_2000;
            default:  return RATE_SCALE_125;
        endcase
    endfunction : imo_scale_factor

endpackage : imo_pkg

// ===== rtl/imo_fifo.sv
`timescale 1ns/1ps
module imo_fifo
    import imo_pkg::*;
#(
    parameter int WIDTH = 192,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wptr;
        logic [PW-1:0]               rptr;
        logic [PW:0]                 count;
        logic                        full;
        logic                        empty;
        logic                        ready;
    } imo_fifo_st_t;

    imo_fifo_st_t q;
    imo_fifo_st_t n;
    logic         push;
    logic         pop;

    // Flags are flops so the ready seen outside has no logic behind it
    assign push      = in_valid && !q.full;
    assign pop       = out_ready && !q.empty;
    assign in_ready  = q.ready;
    assign out_valid = !q.empty;
    assign out_data  = q.mem[q.rptr];

    // Next state
    always_comb begin
        n = q;
        if (push) begin
            n.mem[q.wptr] = in_data;
            n.wptr = (q.wptr == PW'(DEPTH - 1)) ? '0 : q.wptr + 1'b1;
        end
        if (pop) begin
            n.rptr = (q.rptr == PW'(DEPTH - 1)) ? '0 : q.rptr + 1'b1;
        end
        n.count = q.count + (PW+1)'(push) - (PW+1)'(pop);
        n.full  = (n.count == (PW+1)'(DEPTH));
        n.empty = (n.count == '0);
        n.ready = !n.full;
    end

    // State register, frozen while ce is low
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
            q.empty <= 1'b1;
            q.ready <= 1'b1;
        end else if (ce) begin
            q <= n;
        end
    end

    AST_FIFO_NO_OVERFLOW: assert property (@(posedge clk) disable iff (rst)
        ce && q.full && !pop |=> q.count == $past(q.count))
        else $error("fifo count moved while full");
endmodule : imo_fifo

// ===== rtl/imo_axis_fmt.sv
`timescale 1ns/1ps
module imo_axis_fmt
    import imo_pkg::*;
#(
    parameter int          SHIFT  = 0,
    parameter logic [31:0] FS_POS = RATE_FS_POS,
    parameter logic [31:0] FS_NEG = RATE_FS_NEG
) (
    input  wire logic [31:0] raw,
    output imo_axis_t        word
);
    logic signed [31:0] scaled;

    // Coarsen to the variant resolution, then clamp to full scale
    always_comb begin
        scaled = $signed(raw) >>> SHIFT;
        if (scaled > $signed(FS_POS)) begin
            scaled = $signed(FS_POS);
        end else if (scaled < $signed(FS_NEG)) begin
            scaled = $signed(FS_NEG);
        end
        // High word carries the code, low word the extra resolution
        word.hi = scaled[31:16];
        word.lo = scaled[15:0];
    end
endmodule : imo_axis_fmt

// ===== rtl/imo_inertial_regs.sv
`timescale 1ns/1ps
module imo_inertial_regs
    import imo_pkg::*;
#(
    parameter imo_variant_t VARIANT    = VAR_125,
    parameter int           FIFO_DEPTH = 8
) (
    input  wire logic     MCLK,
    input  wire logic     RST,
    input  wire logic     CE,
    input  wire logic     SMP_VALID,
    input  wire imo_raw_t SMP_DATA,
    output logic          SMP_READY,
    input  wire logic     SCLK,
    input  wire logic     CS_N,
    input  wire logic     DIN,
    output logic          DOUT,
    output logic          DATA_LOADED
);
    // Rate arrives at the finest resolution; coarser variants shift it down
    localparam int RATE_SHIFT = $clog2(RATE_SCALE_FINEST / imo_scale_factor(VARIANT));

    typedef enum logic {ST_IDLE, ST_SHIFT} imo_state_t;

    typedef struct packed {
        logic        sclk_m;
        logic        sclk_s;
        logic        sclk_p;
        logic        cs_m;
        logic        cs_s;
        logic        cs_p;
        logic        din_m;
        logic        din_s;
        imo_state_t  st;
        logic [3:0]  bitcnt;
        logic [15:0] rx;
        logic [15:0] tx;
        logic [15:0] resp;
        logic        dout;
        imo_bank_t   bank;
        logic        loaded;
    } imo_main_st_t;

    imo_main_st_t q;
    imo_main_st_t n;
    imo_bank_t    fmt_bank;
    imo_raw_t     fifo_data;
    logic         fifo_valid;
    logic         pop;
    logic         rise;
    logic         fall;
    logic         dec;
    logic [15:0]  cmd;

    // Sample path buffered so the source can run ahead of host reads
    imo_fifo #(
        .WIDTH ($bits(imo_raw_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (MCLK),
        .rst       (RST),
        .ce        (CE),
        .in_valid  (SMP_VALID),
        .in_data   (SMP_DATA),
        .in_ready  (SMP_READY),
        .out_valid (fifo_valid),
        .out_data  (fifo_data),
        .out_ready (pop)
    );

    // One formatter per axis and quantity
    for (genvar i = 0; i < 3; i++) begin : g_axis
        imo_axis_fmt #(
            .SHIFT  (RATE_SHIFT),
            .FS_POS (RATE_FS_POS),
            .FS_NEG (RATE_FS_NEG)
        ) u_rate (
            .raw  (fifo_data.rate[i]),
            .word (fmt_bank.rate[i])
        );
        imo_axis_fmt #(
            .SHIFT  (0),
            .FS_POS (ACCEL_FS_POS),
            .FS_NEG (ACCEL_FS_NEG)
        ) u_accel (
            .raw  (fifo_data.accel[i]),
            .word (fmt_bank.accel[i])
        );
    end

    // Register map lookup on the even byte address
    function automatic logic [15:0] read_word(imo_bank_t b, logic [6:0] a);
        logic [6:0] ea;
        ea = {a[6:1], 1'b0};
        case (ea)
            ADDR_RATE_X_LO:  return b.rate[0].lo;
            ADDR_RATE_X_HI:  return b.rate[0].hi;
            ADDR_RATE_Y_LO:  return b.rate[1].lo;
            ADDR_RATE_Y_HI:  return b.rate[1].hi;
            ADDR_RATE_Z_LO:  return b.rate[2].lo;
            ADDR_RATE_Z_HI:  return b.rate[2].hi;
            ADDR_ACCEL_X_LO: return b.accel[0].lo;
            ADDR_ACCEL_X_HI: return b.accel[0].hi;
            ADDR_ACCEL_Y_LO: return b.accel[1].lo;
            ADDR_ACCEL_Y_HI: return b.accel[1].hi;
            ADDR_ACCEL_Z_LO: return b.accel[2].lo;
            ADDR_ACCEL_Z_HI: return b.accel[2].hi;
            default:         return UNMAPPED_WORD;
        endcase
    endfunction : read_word

    // Edges seen on the second synchroniser stage only
    assign rise = q.sclk_s && !q.sclk_p;
    assign fall = !q.sclk_s && q.sclk_p;
    assign cmd  = {q.rx[14:0], q.din_s};
    assign dec  = (q.st == ST_SHIFT) && !q.cs_s && rise && (q.bitcnt == FRAME_LAST_BIT);
    // Bank loads only between frames, so a reply is never torn mid-shift
    assign pop  = fifo_valid && q.cs_s && q.cs_p;

    // Next state
    always_comb begin
        n = q;
        n.sclk_m = SCLK;
        n.sclk_s = q.sclk_m;
        n.sclk_p = q.sclk_s;
        n.cs_m   = CS_N;
        n.cs_s   = q.cs_m;
        n.cs_p   = q.cs_s;
        n.din_m  = DIN;
        n.din_s  = q.din_m;

        // All six axes load in one cycle from one sample
        if (pop) begin
            n.bank   = fmt_bank;
            n.loaded = 1'b1;
        end

        unique case (q.st)
            ST_IDLE: begin
                n.dout = 1'b0;
                if (!q.cs_s) begin
                    n.st     = ST_SHIFT;
                    n.bitcnt = '0;
                    n.tx     = q.resp;
                end
            end
            ST_SHIFT: begin
                if (q.cs_s) begin
                    // A short frame is dropped; the pending reply stays
                    n.st = ST_IDLE;
                end else if (rise) begin
                    n.rx     = cmd;
                    n.bitcnt = q.bitcnt + 1'b1;
                    if (q.bitcnt == FRAME_LAST_BIT) begin
                        // Writes only yield an empty reply, nothing is stored
                        n.resp = cmd[CMD_WRITE_BIT] ? UNMAPPED_WORD
                                                    : read_word(q.bank, cmd[14:8]);
                        n.tx   = n.resp;
                    end
                end else if (fall) begin
                    // Mode 3: drive on the falling edge, MSB first
                    n.dout = q.tx[15];
                    n.tx   = {q.tx[14:0], 1'b0};
                end
            end
        endcase
    end

    // State register; sample words have no meaningful reset value
    always_ff @(posedge MCLK) begin
        if (RST) begin
            q <= '0;
            q.sclk_m <= 1'b1;
            q.sclk_s <= 1'b1;
            q.sclk_p <= 1'b1;
            q.cs_m   <= 1'b1;
            q.cs_s   <= 1'b1;
            q.cs_p   <= 1'b1;
            q.st     <= ST_IDLE;
            q.resp   <= WORD_RESET;
        end else if (CE) begin
            q <= n;
        end
    end

    assign DOUT        = q.dout;
    assign DATA_LOADED = q.loaded;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    sequence s_read(logic [6:0] a);
        CE && dec && !cmd[CMD_WRITE_BIT] && ({cmd[14:9], 1'b0} == a);
    endsequence

    sequence s_pop_zero_rate;
        CE && pop && (fifo_data.rate[0] == '0);
    endsequence

    AST_READ_RATE_X_HI: assert property (s_read(ADDR_RATE_X_HI) |=> q.resp == $past(q.bank.rate[0].hi))
        else $error("rate x high word reply wrong");
    AST_READ_RATE_Y_LO: assert property (s_read(ADDR_RATE_Y_LO) |=> q.resp == $past(q.bank.rate[1].lo))
        else $error("rate y low word reply wrong");
    AST_READ_RATE_Z_HI: assert property (s_read(ADDR_RATE_Z_HI) |=> q.resp == $past(q.bank.rate[2].hi))
        else $error("rate z high word reply wrong");
    AST_READ_ACCEL_Y_HI: assert property (s_read(ADDR_ACCEL_Y_HI) |=> q.resp == $past(q.bank.accel[1].hi))
        else $error("accel y high word reply wrong");
    AST_BANK_ONLY_ON_POP: assert property (q.bank != $past(q.bank) |-> $past(pop) && $past(CE))
        else $error("bank changed without a sample load");
    AST_BANK_IDLE_ONLY: assert property (q.bank != $past(q.bank) |-> $past(q.cs_s) && $past(q.cs_p))
        else $error("bank changed during a frame");
    AST_ZERO_RATE: assert property (s_pop_zero_rate |=> q.bank.rate[0] == '0)
        else $error("zero rotation not encoded as zero");
    AST_RATE_BOUND: assert property (q.loaded |-> $signed(q.bank.rate[1]) <= $signed(RATE_FS_POS)
        && $signed(q.bank.rate[1]) >= $signed(RATE_FS_NEG))
        else $error("rate word beyond full scale");
    AST_ACCEL_BOUND: assert property (q.loaded |-> $signed(q.bank.accel[2]) <= $signed(ACCEL_FS_POS)
        && $signed(q.bank.accel[2]) >= $signed(ACCEL_FS_NEG))
        else $error("accel word beyond full scale");
    AST_WRITE_EMPTY_REPLY: assert property (CE && dec && cmd[CMD_WRITE_BIT] |=> q.resp == UNMAPPED_WORD)
        else $error("write frame produced a data reply");

    // Addresses outside the map, as the decoder sees them after the even-byte fold
    sequence s_read_unmapped;
        CE && dec && !cmd[CMD_WRITE_BIT]
            && (({cmd[14:9], 1'b0} < ADDR_RATE_X_LO) || ({cmd[14:9], 1'b0} > ADDR_ACCEL_Z_HI));
    endsequence

    // Select rises while a frame is open
    sequence s_frame_cut;
        CE && (q.st == ST_SHIFT) && q.cs_s;
    endsequence

    // Sample load with a chosen sign on the y rate
    sequence s_pop_sign(logic neg);
        CE && pop && (fifo_data.rate[1][31] == neg);
    endsequence

    // Every remaining word of the map is watched, so no decode slip goes unseen
    AST_READ_RATE_X_LO: assert property (s_read(ADDR_RATE_X_LO)
        |=> q.resp == $past(q.bank.rate[0].lo))
        else $error("rate x low word reply wrong");
    AST_READ_RATE_Y_HI: assert property (s_read(ADDR_RATE_Y_HI)
        |=> q.resp == $past(q.bank.rate[1].hi))
        else $error("rate y high word reply wrong");
    AST_READ_RATE_Z_LO: assert property (s_read(ADDR_RATE_Z_LO)
        |=> q.resp == $past(q.bank.rate[2].lo))
        else $error("rate z low word reply wrong");
    AST_READ_ACCEL_X_LO: assert property (s_read(ADDR_ACCEL_X_LO)
        |=> q.resp == $past(q.bank.accel[0].lo))
        else $error("accel x low word reply wrong");
    AST_READ_ACCEL_X_HI: assert property (s_read(ADDR_ACCEL_X_HI)
        |=> q.resp == $past(q.bank.accel[0].hi))
        else $error("accel x high word reply wrong");
    AST_READ_ACCEL_Y_LO: assert property (s_read(ADDR_ACCEL_Y_LO)
        |=> q.resp == $past(q.bank.accel[1].lo))
        else $error("accel y low word reply wrong");
    AST_READ_ACCEL_Z_LO: assert property (s_read(ADDR_ACCEL_Z_LO)
        |=> q.resp == $past(q.bank.accel[2].lo))
        else $error("accel z low word reply wrong");
    AST_READ_ACCEL_Z_HI: assert property (s_read(ADDR_ACCEL_Z_HI)
        |=> q.resp == $past(q.bank.accel[2].hi))
        else $error("accel z high word reply wrong");
    AST_READ_UNMAPPED: assert property (s_read_unmapped
        |=> q.resp == UNMAPPED_WORD)
        else $error("unmapped address gave a data reply");

    // Bank and reply integrity around frames
    AST_BANK_FROM_SAMPLE: assert property (CE && pop
        |=> q.bank == $past(fmt_bank))
        else $error("bank does not hold the popped sample");
    AST_LOADED_STICKY: assert property (q.loaded
        |=> q.loaded)
        else $error("loaded flag dropped without reset");
    AST_CUT_FRAME_KEEPS_REPLY: assert property (s_frame_cut
        |=> q.resp == $past(q.resp))
        else $error("reply changed at frame end");
    AST_WRITE_KEEPS_BANK: assert property (CE && dec && cmd[CMD_WRITE_BIT]
        |=> q.bank == $past(q.bank))
        else $error("write frame changed the bank");

    // Sign survives the variant shift and the clamp
    AST_RATE_SIGN_NEG: assert property (s_pop_sign(1'b1)
        |=> q.bank.rate[1].hi[15])
        else $error("negative rate lost its sign");
    AST_RATE_SIGN_POS: assert property (s_pop_sign(1'b0)
        |=> !q.bank.rate[1].hi[15])
        else $error("positive rate read as negative");

    // Remaining axes stay inside full scale
    AST_RATE_X_BOUND: assert property (q.loaded |-> $signed(q.bank.rate[0]) <= $signed(RATE_FS_POS)
        && $signed(q.bank.rate[0]) >= $signed(RATE_FS_NEG))
        else $error("rate x beyond full scale");
    AST_RATE_Z_BOUND: assert property (q.loaded |-> $signed(q.bank.rate[2]) <= $signed(RATE_FS_POS)
        && $signed(q.bank.rate[2]) >= $signed(RATE_FS_NEG))
        else $error("rate z beyond full scale");
    AST_ACCEL_X_BOUND: assert property (q.loaded |-> $signed(q.bank.accel[0]) <= $signed(ACCEL_FS_POS)
        && $signed(q.bank.accel[0]) >= $signed(ACCEL_FS_NEG))
        else $error("accel x beyond full scale");
    AST_ACCEL_Y_BOUND: assert property (q.loaded |-> $signed(q.bank.accel[1]) <= $signed(ACCEL_FS_POS)
        && $signed(q.bank.accel[1]) >= $signed(ACCEL_FS_NEG))
        else $error("accel y beyond full scale");
endmodule : imo_inertial_regs

// ===== verification/imo_spi_host.sv
`timescale 1ns/1ps
module imo_spi_host (
    input  wire logic clk,
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic dout,
    input  wire logic dout_b
);
    // Reply of the second block on the shared select, kept from the last frame
    logic [15:0] rsp_b;

    // Mode 3 host: clock idles high and stands still between frames
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din  = 1'b0;
    end

    // Move just after an edge so no race with the block's flops
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // Select gap covers the block's synchroniser fill
    task automatic select(input logic en);
        tick(6);
        cs_n = ~en;
        tick(6);
    endtask : select

    // One 16-bit frame, MSB first; phases of 6 cycles beat the 3-cycle minimum
    task automatic frame(input logic [15:0] cmd, output logic [15:0] rsp);
        for (int i = 15; i >= 0; i--) begin
            sclk = 1'b0;
            din  = cmd[i];
            tick(6);
            rsp[i]   = dout;
            rsp_b[i] = dout_b;
            sclk     = 1'b1;
            tick(6);
        end
        // Released data line shows no stale bit
        din = ~din;
    endtask : frame
endmodule : imo_spi_host

// ===== verification/imo_inertial_regs_tb.sv
`timescale 1ns/1ps
module imo_inertial_regs_tb;
    import imo_pkg::*;

    logic     MCLK;
    logic     RST;
    logic     CE;
    logic     SMP_VALID;
    imo_raw_t SMP_DATA;
    logic     SMP_READY;
    logic     SCLK;
    logic     CS_N;
    logic     DIN;
    logic     DOUT;
    logic     DATA_LOADED;
    logic     DOUT_W;
    logic     SMP_READY_W;
    logic     DATA_LOADED_W;
    int       n_fail     = 0;
    int       num_checks = 0;
    // Word addresses: rate x/y/z low, high, then accel x/y/z low, high
    logic [6:0] addrs [12] = '{7'h04, 7'h06, 7'h08, 7'h0a, 7'h0c, 7'h0e,
                               7'h10, 7'h12, 7'h14, 7'h16, 7'h18, 7'h1a};

    imo_inertial_regs dut (.MCLK(MCLK), .RST(RST), .CE(CE), .SMP_VALID(SMP_VALID), .SMP_DATA(SMP_DATA),
        .SMP_READY(SMP_READY), .SCLK(SCLK), .CS_N(CS_N), .DIN(DIN), .DOUT(DOUT), .DATA_LOADED(DATA_LOADED));
    // Coarsest variant beside the default one, fed the same stimulus
    imo_inertial_regs #(.VARIANT(VAR_2000)) dut_wide (.MCLK(MCLK), .RST(RST), .CE(CE), .SMP_VALID(SMP_VALID),
        .SMP_DATA(SMP_DATA), .SMP_READY(SMP_READY_W), .SCLK(SCLK), .CS_N(CS_N), .DIN(DIN), .DOUT(DOUT_W),
        .DATA_LOADED(DATA_LOADED_W));
    imo_spi_host host (.clk(MCLK), .sclk(SCLK), .cs_n(CS_N), .din(DIN), .dout(DOUT), .dout_b(DOUT_W));

    initial begin
        MCLK = 1'b0;
        forever #2 MCLK = ~MCLK;
    end

    task automatic conclude();
        $display("checks=%0d failures=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Offer a sample for up to lim edges; ok tells whether it was taken
    task automatic push(input imo_raw_t s, input int lim, output logic ok);
        SMP_DATA  = s;
        SMP_VALID = 1'b1;
        ok        = 1'b0;
        for (int k = 0; k < lim && !ok; k++) begin
            ok = (SMP_READY === 1'b1);
            host.tick(1);
        end
        SMP_VALID = 1'b0;
        // Let an edge pass so a following offer never re-raises valid in this step
        host.tick(1);
    endtask : push

    // All twelve words in one select; replies lag one frame
    task automatic rd_all(input logic [15:0] exp [12]);
        logic [15:0] r;
        host.select(1'b1);
        for (int i = 0; i <= 12; i++) begin
            host.frame({1'b0, addrs[i % 12], 8'h00}, r);
            if (i > 0) check(r, exp[i-1]);
        end
        host.select(1'b0);
    endtask : rd_all

    // Clamping at full scale, sign and low-word resolution
    task automatic t_format();
        imo_raw_t    s;
        logic        ok;
        logic [15:0] e [12] = '{16'h0000, 16'h4e20, 16'h0000, 16'hb1e0, 16'hfffe, 16'h0001,
                                16'h0000, 16'h7d00, 16'h0000, 16'h8300, 16'hfffe, 16'hffff};
        s          = '0;
        s.rate[0]  = 32'h7fffffff;
        s.rate[1]  = 32'h80000000;
        s.rate[2]  = 32'h0001fffe;
        s.accel[0] = 32'h7fffffff;
        s.accel[1] = 32'h80000000;
        s.accel[2] = 32'hfffffffe;
        check({15'h0, DATA_LOADED}, 16'h0000);
        push(s, 20, ok);
        check({15'h0, ok}, 16'h0001);
        host.tick(4);
        check({15'h0, DATA_LOADED}, 16'h0001);
        rd_all(e);
        $display("test format done");
    endtask : t_format

    // Writes, odd and unmapped addresses
    task automatic t_write();
        logic [15:0] r;
        host.select(1'b1);
        host.frame({1'b1, 7'h06, 8'h55}, r);
        host.frame({1'b0, 7'h07, 8'h00}, r);
        check(r, 16'h0000);
        host.frame({1'b0, 7'h30, 8'h00}, r);
        check(r, 16'h4e20);
        host.frame({1'b0, 7'h0b, 8'h00}, r);
        check(r, 16'h0000);
        host.frame(16'h0000, r);
        check(r, 16'hb1e0);
        host.select(1'b0);
        $display("test write done");
    endtask : t_write

    // Fill the buffer while a select stalls the bank, then drain it
    task automatic t_fifo();
        imo_raw_t    s;
        logic        ok;
        logic [15:0] r;
        int          cnt;
        s   = '0;
        cnt = 0;
        host.select(1'b1);
        for (int k = 0; k < 12; k++) begin
            s.rate[0] = {16'(k), 16'(k + 16'h00a0)};
            push(s, 3, ok);
            if (!ok) break;
            cnt++;
        end
        check(16'(cnt), 16'h0008);
        check({15'h0, SMP_READY}, 16'h0000);
        host.frame({1'b0, 7'h04, 8'h00}, r);
        host.frame({1'b0, 7'h06, 8'h00}, r);
        check(r, 16'h0000);
        host.frame(16'h0000, r);
        check(r, 16'h4e20);
        host.select(1'b0);
        host.tick(30);
        check({15'h0, SMP_READY}, 16'h0001);
        host.select(1'b1);
        host.frame({1'b0, 7'h04, 8'h00}, r);
        host.frame({1'b0, 7'h06, 8'h00}, r);
        check(r, 16'h00a7);
        host.frame(16'h0000, r);
        check(r, 16'h0007);
        host.select(1'b0);
        $display("test fifo done");
    endtask : t_fifo

    // Mid-run reset, a frozen clock enable, then one sample read from both variants
    task automatic t_restart();
        imo_raw_t    s;
        logic        ok;
        logic [15:0] r;
        logic [15:0] ea [4] = '{16'h0000, 16'h0010, 16'hfff0, 16'h0010};
        logic [15:0] eb [4] = '{16'h0000, 16'h0001, 16'hffff, 16'h0001};
        logic [6:0]  ra [5] = '{7'h04, 7'h0a, 7'h0e, 7'h0c, 7'h00};
        s         = '0;
        s.rate[1] = 32'h00100000;
        s.rate[2] = 32'hfff00010;
        // Held over several edges so no watched value jumps at release
        RST = 1'b1;
        host.tick(6);
        RST = 1'b0;
        host.tick(1);
        check({14'h0, DATA_LOADED, DATA_LOADED_W}, 16'h0000);
        check({14'h0, SMP_READY, SMP_READY_W}, 16'h0003);
        check({14'h0, DOUT, DOUT_W}, 16'h0000);
        // Offer the sample with the enable low: nothing may be taken
        CE        = 1'b0;
        SMP_DATA  = s;
        SMP_VALID = 1'b1;
        host.tick(8);
        SMP_VALID = 1'b0;
        CE        = 1'b1;
        host.tick(4);
        check({14'h0, DATA_LOADED, DATA_LOADED_W}, 16'h0000);
        push(s, 20, ok);
        check({15'h0, ok}, 16'h0001);
        host.tick(4);
        check({14'h0, DATA_LOADED, DATA_LOADED_W}, 16'h0003);
        host.select(1'b1);
        for (int i = 0; i < 5; i++) begin
            host.frame({1'b0, ra[i], 8'h00}, r);
            if (i > 0) begin
                check(r, ea[i-1]);
                check(host.rsp_b, eb[i-1]);
            end
        end
        host.select(1'b0);
        $display("test restart done");
    endtask : t_restart

    // Watchdog against a hang
    initial begin
        #200000;
        n_fail++;
        conclude();
    end

    initial begin
        RST       = 1'b1;
        CE        = 1'b1;
        SMP_VALID = 1'b0;
        SMP_DATA  = '0;
        repeat (6) @(posedge MCLK);
        #1;
        RST = 1'b0;
        host.tick(1);
        check({15'h0, SMP_READY}, 16'h0001);
        check({15'h0, DOUT}, 16'h0000);
        t_format();
        t_write();
        t_fifo();
        t_restart();
        conclude();
    end
endmodule : imo_inertial_regs_tb
